//--- verification/test_vram_host.sv
`include "vram_host_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module test_vram_host;
    logic clk_in = 1'b0, rstn_in = 1'b0, ce_in = 1'b1, req_valid_in = 1'b0;
    logic mask_en_in = 1'b0, page_in = 1'b0;
    logic [2:0] op_in = 3'h0;
    logic [16:0] addr_in = 17'h00000, a;
    logic [7:0] wdata_in = 8'h00, mask_in = 8'h00, d;
    wire rdy, rvld, init_done, ras_n, cas_n, we_n, oe_n, special_function_select, pin_oe;
    wire [7:0] rdata, pin_out, dev_dq, pin_in;
    wire [8:0] a_pins;
    wire [15:0] cbr_cnt;
    int mismatches = 0, checked = 0, cyc = 0, c0;
    logic [7:0] sh [int];
    assign pin_in = pin_oe ? pin_out : dev_dq;
    vram_host #(.REF_CYCLES(50), .PWRUP_CYCLES(20)) DUT (.clk_in(clk_in), .rstn_in(rstn_in),
        .ce_in(ce_in), .req_valid_in(req_valid_in), .op_in(op_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .mask_in(mask_in), .mask_en_in(mask_en_in), .page_in(page_in),
        .req_ready_out(rdy), .rdata_valid_out(rvld), .rdata_out(rdata), .init_done_out(init_done),
        .ras_n_out(ras_n), .cas_n_out(cas_n), .mask_write_enable_n_out(we_n),
        .transfer_output_enable_n_out(oe_n), .special_function_select_out(special_function_select),
        .addr_out(a_pins), .mask_or_data_pin_out(pin_out), .mask_or_data_pin_oe_out(pin_oe),
        .mask_or_data_pin_in(pin_in));
    vram_dev_model u_dev (.ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .oe_n_in(oe_n),
        .dsf_in(special_function_select), .a_in(a_pins), .dq_in(pin_in), .dq_out(dev_dq), .cbr_cnt_out(cbr_cnt));
    initial forever #10 clk_in = ~clk_in;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // a hang ends the run as a failure
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            mismatches++;
            wrap_up();
        end
    end
    // hold the request until ready is seen, then drop it after the taking edge
    task automatic req(input logic [2:0] op, input logic [16:0] ad, input logic [7:0] wd,
                       input logic [7:0] mk, input logic me, input logic pg);
        @(posedge clk_in);
        op_in <= op;
        addr_in <= ad;
        wdata_in <= wd;
        mask_in <= mk;
        mask_en_in <= me;
        page_in <= pg;
        req_valid_in <= 1'b1;
        do @(negedge clk_in); while (rdy !== 1'b1);
        @(posedge clk_in);
        req_valid_in <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] op, input logic [16:0] ad, input logic [7:0] dn,
                      input logic [7:0] mk, input logic me, input logic pg);
        logic [7:0] old;
        old = sh.exists(ad) ? sh[ad] : 8'h00;
        sh[ad] = me ? ((old & ~mk) | (dn & mk)) : dn;
        req(op, ad, dn, mk, me, pg);
    endtask
    task automatic rd(input logic [16:0] ad, input logic pg);
        int n;
        n = 0;
        req(`OP_READ, ad, 8'h00, 8'h00, 1'b0, pg);
        do begin @(negedge clk_in); n++; end while (rvld !== 1'b1 && n < 100);
        check("read word", rdata, sh[ad]);
    endtask
    initial begin
        a = $urandom(30798);
        repeat (16) @(posedge clk_in);
        rstn_in <= 1'b1;
        while (init_done !== 1'b1) @(posedge clk_in);
        check("init refresh", {7'h00, cbr_cnt >= 16'h0008}, 8'h01);
        $display("test init done");
        // corner addresses first, then random; second write or rmw, masked unless i is a multiple of 3
        for (int i = 0; i < 24; i++) begin
            a = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1FFFF : 17'($urandom);
            d = 8'($urandom);
            wr(`OP_WRITE, a, 8'($urandom), 8'hFF, 1'b0, 1'b0);
            wr(i[0] ? `OP_RMW : `OP_WRITE, a, d, 8'($urandom), i % 3 != 0, 1'b0);
            rd(a, 1'b0);
        end
        $display("test masked words done");
        // page mode with writes and reads mixed on one row
        for (int i = 0; i < 4; i++) begin
            wr(`OP_WRITE, {9'h0AB, 8'(i)}, 8'($urandom), 8'hFF, 1'b0, 1'b1);
            rd({9'h0AB, 8'(i)}, i < 3);
        end
        $display("test page mode done");
        req(`OP_FLASH, {9'h055, 8'h00}, 8'h00, 8'hFF, 1'b1, 1'b0);
        for (int i = 0; i < 256; i++) sh[{9'h055, 8'(i)}] = 8'h5A;
        rd({9'h055, 8'h00}, 1'b0);
        rd({9'h055, 8'hFF}, 1'b0);
        $display("test flash done");
        for (int i = 0; i < 4; i++) wr(`OP_WRITE, {9'h055, 8'h10 + 8'(i)}, 8'h00, 8'hFF, 1'b0, 1'b0);
        req(`OP_BLOCK, {9'h055, 8'h13}, 8'h05, 8'hFF, 1'b0, 1'b0);
        sh[{9'h055, 8'h10}] = 8'h5A;
        sh[{9'h055, 8'h12}] = 8'h5A;
        for (int i = 0; i < 4; i++) rd({9'h055, 8'h10 + 8'(i)}, 1'b0);
        $display("test block done");
        c0 = cbr_cnt;
        repeat (200) @(posedge clk_in);
        check("idle refresh", {7'h00, cbr_cnt - 16'(c0) >= 16'h0003}, 8'h01);
        $display("test refresh done");
        wrap_up();
    end
endmodule // test_vram_host
`default_nettype wire

//--- verification/vram_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module vram_dev_model #(
    parameter logic [7:0] COLOR = 8'h5A // arbitrary fill for flash and block writes
) (
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic dsf_in,
    input wire logic [8:0] a_in,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic [15:0] cbr_cnt_out = 16'h0000
);
    logic [7:0] mem [0:131071];
    logic [8:0] row_q;
    logic [7:0] col_q, wm_q, rd_q, last_q = 8'h00;
    logic wm_en_q = 1'b0, blk_q = 1'b0, early_q = 1'b0, done_q = 1'b1, live_q = 1'b0;
    logic drive;
    // masked store; the mask only lives for this row cycle
    task automatic put(input logic [16:0] adr, input logic [7:0] d);
        mem[adr] = wm_en_q ? ((mem[adr] & ~wm_q) | (d & wm_q)) : d;
        done_q = 1'b1;
    endtask
    // row strobe fall decodes the cycle
    always @(negedge ras_n_in) begin
        if (!cas_n_in) begin
            cbr_cnt_out = cbr_cnt_out + 16'h0001;
        end else begin
            row_q = a_in;
            wm_en_q = !we_n_in;
            wm_q = dq_in;
            blk_q = !dsf_in && oe_n_in;
            if (!we_n_in && dsf_in) begin
                for (int i = 0; i < 256; i++) put({a_in, i[7:0]}, COLOR);
            end
        end
    end
    // column fall: block write ignores the two low column bits
    always @(negedge cas_n_in) begin
        if (!ras_n_in) begin
            col_q = a_in[7:0];
            rd_q = mem[{row_q, col_q}];
            early_q = !we_n_in;
            live_q = 1'b1;
            done_q = 1'b0;
            if (blk_q && dsf_in) begin
                for (int i = 0; i < 4; i++) if (dq_in[i]) put({row_q, a_in[7:2], i[1:0]}, COLOR);
                done_q = 1'b1;
            end else if (!we_n_in) begin
                put({row_q, col_q}, dq_in);
            end
        end
    end
    // late write enable stores what is on the pins then
    always @(negedge we_n_in) if (!ras_n_in && !cas_n_in && !done_q) put({row_q, col_q}, dq_in);
    always @(posedge cas_n_in) live_q = 1'b0;
    // drive only with both low; released pins show the inverse
    assign drive = live_q && !cas_n_in && !oe_n_in && !early_q;
    always @(drive or rd_q) if (drive) last_q = rd_q;
    assign dq_out = drive ? rd_q : ~last_q;
endmodule // vram_dev_model
`default_nettype wire

//--- verification/vram_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
module vram_host_chk #(
    parameter integer REF_CYCLES = 50,
    parameter integer PWRUP_CYCLES = 20
) (
    input wire clk_in,
    input wire rstn_in,
    input wire req_ready_out,
    input wire init_done_out,
    input wire ras_n_out,
    input wire cas_n_out,
    input wire mask_write_enable_n_out,
    input wire transfer_output_enable_n_out,
    input wire mask_or_data_pin_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    logic [15:0] up_q, cbr_q, ref_q;
    logic cbr_fall;
    assign cbr_fall = !ras_n_out && !cas_n_out;
    // counters: time since reset (saturating), refresh cycles and time since refresh (both wrap)
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            up_q <= 16'h0000;
            cbr_q <= 16'h0000;
            ref_q <= 16'h0000;
        end else begin
            up_q <= (up_q == 16'hFFFF) ? up_q : up_q + 16'h0001;
            cbr_q <= ($fell(ras_n_out) && cbr_fall) ? cbr_q + 16'h0001 : cbr_q;
            ref_q <= ($fell(ras_n_out) && cbr_fall) ? 16'h0000 : ref_q + 16'h0001;
        end
    end
    property p_rcd; ($fell(cas_n_out) && !ras_n_out) |-> $past(ras_n_out, 2) == 1'b0; endproperty
    a_rcd: assert property (p_rcd) else $error("column strobe too soon after row");
    property p_pre; $rose(ras_n_out) |-> ras_n_out [*3]; endproperty
    a_pre: assert property (p_pre) else $error("row precharge too short");
    property p_ras; $fell(ras_n_out) |-> (ras_n_out == 1'b0) [*4]; endproperty
    a_ras: assert property (p_ras) else $error("row strobe low too short");
    property p_bus; mask_or_data_pin_oe_out |-> cas_n_out || transfer_output_enable_n_out; endproperty
    a_bus: assert property (p_bus) else $error("data pins driven by both sides");
    property p_wd; ($fell(mask_write_enable_n_out) && !cas_n_out && !ras_n_out)
        || ($fell(cas_n_out) && !mask_write_enable_n_out && !ras_n_out) |-> mask_or_data_pin_oe_out;
    endproperty
    a_wd: assert property (p_wd) else $error("write data missing at strobe");
    property p_msk; ($fell(ras_n_out) && cas_n_out && !mask_write_enable_n_out)
        |-> mask_or_data_pin_oe_out; endproperty
    a_msk: assert property (p_msk) else $error("mask not on pins at row fall");
    property p_csr; ($fell(ras_n_out) && !cas_n_out) |-> $past(cas_n_out) == 1'b0; endproperty
    a_csr: assert property (p_csr) else $error("refresh column setup too short");
    property p_pwr; ($fell(ras_n_out) && !init_done_out) |-> up_q >= PWRUP_CYCLES; endproperty
    a_pwr: assert property (p_pwr) else $error("row strobe before power-up wait");
    property p_init; $rose(init_done_out) |-> cbr_q >= 16'h0008; endproperty
    a_init: assert property (p_init) else $error("too few init refresh cycles");
    property p_rdy; req_ready_out |-> init_done_out; endproperty
    a_rdy: assert property (p_rdy) else $error("ready before init");
    property p_ref; init_done_out |-> ref_q < 2 * REF_CYCLES + 64; endproperty
    a_ref: assert property (p_ref) else $error("refresh overdue");
endmodule // vram_host_chk
bind vram_host vram_host_chk #(.REF_CYCLES(REF_CYCLES), .PWRUP_CYCLES(PWRUP_CYCLES)) u_chk (
    .clk_in(clk_in), .rstn_in(rstn_in), .req_ready_out(req_ready_out),
    .init_done_out(init_done_out), .ras_n_out(ras_n_out), .cas_n_out(cas_n_out),
    .mask_write_enable_n_out(mask_write_enable_n_out),
    .transfer_output_enable_n_out(transfer_output_enable_n_out),
    .mask_or_data_pin_oe_out(mask_or_data_pin_oe_out));
`default_nettype wire

//--- verilog/vram_host.v
`include "vram_host_defines.vh"
`timescale 1ns/1ps
`default_nettype none
// Operation
// - word address is 9 row bits then 8 column bits on shared pins
// - row latched on row strobe fall with column strobe high, then column
// - cycle ends with both strobes high; row strobe held high for precharge
// - never end a cycle before both strobe minimum low widths elapse
// - write enable held high through the cycle makes it a read
// - write data presented by the later of column strobe or write enable fall
// - page mode keeps row strobe low while column strobe toggles
// - write enable low at row strobe fall captures the per-bit mask
// - block write: special function low at row fall, high at column fall
// - block write latches column bits 7..2 with column mask data
// - flash write: column high, write enable low, special high at row fall
// - refresh all 512 rows within every 8 ms
// - row-only refresh walks all 512 row addresses on nine pins; unused here, refresh is column strobe first
// - after power-up wait 200 us then 8 init cycles
// - hidden refresh toggles row strobe with column strobe held low; unused here, reads end before refresh starts
module vram_host #(
    parameter integer REF_CYCLES = `T_REF_US * 1000 / `T_CLK_NS / `ROWS,
    parameter integer PWRUP_CYCLES = `T_PWRUP_US * 1000 / `T_CLK_NS
) (
    input wire clk_in,
    input wire rstn_in,
    input wire ce_in,
    input wire req_valid_in,
    input wire [2:0] op_in,
    input wire [16:0] addr_in,
    input wire [7:0] wdata_in,
    input wire [7:0] mask_in,
    input wire mask_en_in,
    input wire page_in,
    output wire req_ready_out,
    output reg rdata_valid_out,
    output reg [7:0] rdata_out,
    output reg init_done_out,
    output reg ras_n_out,
    output reg cas_n_out,
    output reg mask_write_enable_n_out,
    output reg transfer_output_enable_n_out,
    output reg special_function_select_out,
    output reg [8:0] addr_out,
    output reg [7:0] mask_or_data_pin_out,
    output reg mask_or_data_pin_oe_out,
    input wire [7:0] mask_or_data_pin_in
);
    // cycle counts: least times round up
    localparam [7:0] C_RP = (`T_RP_NS + `T_CLK_NS - 1) / `T_CLK_NS;
    localparam [7:0] C_RAS = (`T_RAS_NS + `T_CLK_NS - 1) / `T_CLK_NS;
    localparam [7:0] C_RCD = (`T_RCD_NS + `T_CLK_NS - 1) / `T_CLK_NS;
    localparam [7:0] C_CAS = (`T_CAS_NS + `T_CLK_NS - 1) / `T_CLK_NS;
    localparam [7:0] C_CP = (`T_CP_NS + `T_CLK_NS - 1) / `T_CLK_NS;
    localparam [7:0] C_CSR = (`T_CSR_NS + `T_CLK_NS - 1) / `T_CLK_NS;
    localparam [7:0] C_CHR = (`T_CHR_NS + `T_CLK_NS - 1) / `T_CLK_NS;
    localparam [7:0] C_CWD = (`T_CWD_NS + `T_CLK_NS - 1) / `T_CLK_NS;
    localparam [7:0] C_WCH = (`T_WCH_NS + `T_CLK_NS - 1) / `T_CLK_NS;
    // access wait plus two synchroniser stages
    localparam [7:0] C_ACC = (`T_CAC_NS + `T_OEA_NS + `T_CLK_NS - 1) / `T_CLK_NS + 8'h2;
    // one-hot states
    localparam [9:0] S_PWR = 10'h001;
    localparam [9:0] S_IDLE = 10'h002;
    localparam [9:0] S_RAS = 10'h004;
    localparam [9:0] S_CAS = 10'h008;
    localparam [9:0] S_WAIT = 10'h010;
    localparam [9:0] S_WE = 10'h020;
    localparam [9:0] S_CUP = 10'h040;
    localparam [9:0] S_RUP = 10'h080;
    localparam [9:0] S_PRE = 10'h100;
    localparam [9:0] S_CBR = 10'h200;

    reg [9:0] state_q;
    reg [31:0] cnt_q;
    reg [31:0] ref_cnt_q;
    reg ref_pend_q;
    reg [3:0] init_cnt_q;
    reg [2:0] op_q;
    reg [7:0] col_q;
    reg [7:0] wdata_q;
    reg page_q;
    reg [7:0] ras_len_q;
    reg [7:0] sync1_q;
    reg [7:0] sync2_q;
    reg [8:0] row_q;
    wire page_hit;

    // pin data passes two flops before capture
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end else if (ce_in) begin
            sync1_q <= mask_or_data_pin_in;
            sync2_q <= sync1_q;
        end
    end

    // a same-row request may join an open page; flash needs its own row cycle
    assign page_hit = req_valid_in && (addr_in[16:8] == row_q) && !ref_pend_q &&
        (op_in != `OP_FLASH);

    // a new request is taken at idle after precharge, or into an open page
    assign req_ready_out = ce_in && init_done_out &&
        (((state_q == S_IDLE) && !ref_pend_q && (cnt_q >= C_RP - 1)) ||
        ((state_q == S_PRE) && (cnt_q >= C_CP - 1) && page_hit));

    function is_write;
        input [2:0] op;
        begin
            is_write = (op == `OP_WRITE) || (op == `OP_BLOCK);
        end
    endfunction

    // main sequencer
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= S_PWR;
            cnt_q <= 32'h0;
            ref_cnt_q <= 32'h0;
            ref_pend_q <= 1'b0;
            init_cnt_q <= 4'h0;
            init_done_out <= 1'b0;
            op_q <= `OP_READ;
            col_q <= 8'h00;
            wdata_q <= 8'h00;
            page_q <= 1'b0;
            ras_len_q <= 8'h00;
            row_q <= 9'h000;
            rdata_valid_out <= 1'b0;
            rdata_out <= 8'h00;
            ras_n_out <= 1'b1;
            cas_n_out <= 1'b1;
            mask_write_enable_n_out <= 1'b1;
            transfer_output_enable_n_out <= 1'b1;
            special_function_select_out <= 1'b0;
            addr_out <= 9'h000;
            mask_or_data_pin_out <= 8'h00;
            mask_or_data_pin_oe_out <= 1'b0;
        end else if (ce_in) begin
            rdata_valid_out <= 1'b0;
            cnt_q <= cnt_q + 32'h1;
            if (ras_len_q != 8'hFF && !ras_n_out)
                ras_len_q <= ras_len_q + 8'h1;
            // interval timer: one row refresh per slot keeps 512 rows in 8 ms
            if (ref_cnt_q >= REF_CYCLES - 1) begin
                ref_cnt_q <= 32'h0;
                ref_pend_q <= 1'b1;
            end else begin
                ref_cnt_q <= ref_cnt_q + 32'h1;
            end
            case (state_q)
                S_PWR: begin
                    if (cnt_q >= PWRUP_CYCLES - 1) begin
                        state_q <= S_CBR;
                        cnt_q <= 32'h0;
                    end
                end
                S_IDLE: begin
                    // cnt_q runs on from the row strobe rise: nothing starts before precharge
                    if (cnt_q < C_RP - 1) begin
                        state_q <= S_IDLE;
                    end else if (ref_pend_q) begin
                        // column strobe first selects internal row counter
                        // row-only refresh unused: the device counter walks all rows
                        // no hidden refresh: reads end before refresh starts
                        cas_n_out <= 1'b0;
                        cnt_q <= 32'h0;
                        state_q <= S_CBR;
                    end else if (req_valid_in) begin
                        op_q <= op_in;
                        row_q <= addr_in[16:8];
                        col_q <= addr_in[7:0];
                        wdata_q <= wdata_in;
                        page_q <= page_in;
                        addr_out <= addr_in[16:8];
                        // special function low at row fall except flash
                        special_function_select_out <= (op_in == `OP_FLASH);
                        // write enable low at row fall arms the mask
                        mask_write_enable_n_out <= !(mask_en_in || op_in == `OP_FLASH);
                        // mask bits drive pins: one writes, zero blocks
                        mask_or_data_pin_out <= mask_in;
                        mask_or_data_pin_oe_out <= mask_en_in || (op_in == `OP_FLASH);
                        transfer_output_enable_n_out <= 1'b1;
                        state_q <= S_RAS;
                    end
                end
                S_RAS: begin
                    // row strobe falls with column strobe high
                    if (ras_n_out) begin
                        ras_n_out <= 1'b0;
                        ras_len_q <= 8'h0;
                        cnt_q <= 32'h0;
                    end else if (cnt_q >= C_RCD - 1) begin
                        // mask was for this cycle only; release pins
                        mask_or_data_pin_oe_out <= 1'b0;
                        mask_write_enable_n_out <= 1'b1;
                        if (op_q == `OP_FLASH) begin
                            // flash write needs no column phase
                            state_q <= S_RUP;
                        end else begin
                            addr_out <= {1'b0, col_q};
                            // data, write enable and function settle before column fall
                            mask_write_enable_n_out <= !is_write(op_q);
                            mask_or_data_pin_out <= wdata_q;
                            mask_or_data_pin_oe_out <= is_write(op_q);
                            special_function_select_out <= (op_q == `OP_BLOCK);
                            // block write: low column bits ignored
                            if (op_q == `OP_BLOCK)
                                addr_out[`BLK_COL_LSB-1:0] <= 2'b00;
                            state_q <= S_CAS;
                            cnt_q <= 32'h0;
                        end
                    end
                end
                S_CAS: begin
                    // special function high at column fall for block write
                    special_function_select_out <= (op_q == `OP_BLOCK);
                    // data ready at column strobe fall; early write
                    if (is_write(op_q)) begin
                        mask_write_enable_n_out <= 1'b0;
                        mask_or_data_pin_out <= wdata_q;
                        mask_or_data_pin_oe_out <= 1'b1;
                    end else begin
                        // write enable stays high for reads; enable output
                        transfer_output_enable_n_out <= 1'b0;
                    end
                    cas_n_out <= 1'b0;
                    cnt_q <= 32'h0;
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    // wait access delay before sampling read data
                    if (is_write(op_q)) begin
                        if (cnt_q >= C_WCH - 1 && cnt_q >= C_CAS - 1)
                            state_q <= S_CUP;
                    end else if (cnt_q >= C_ACC - 1 && cnt_q >= C_CWD - 1) begin
                        // data held while column strobe low
                        rdata_out <= sync2_q;
                        rdata_valid_out <= 1'b1;
                        if (op_q == `OP_RMW) begin
                            // late write enable after data was shown
                            transfer_output_enable_n_out <= 1'b1;
                            mask_or_data_pin_out <= wdata_q;
                            state_q <= S_WE;
                            cnt_q <= 32'h0;
                        end else begin
                            state_q <= S_CUP;
                        end
                    end
                end
                S_WE: begin
                    // data out before write enable falls
                    mask_or_data_pin_oe_out <= 1'b1;
                    if (cnt_q == 32'h1)
                        mask_write_enable_n_out <= 1'b0;
                    if (cnt_q >= C_WCH + 1)
                        state_q <= S_CUP;
                end
                S_CUP: begin
                    cas_n_out <= 1'b1;
                    mask_write_enable_n_out <= 1'b1;
                    mask_or_data_pin_oe_out <= 1'b0;
                    transfer_output_enable_n_out <= 1'b1;
                    special_function_select_out <= 1'b0;
                    cnt_q <= 32'h0;
                    // page mode: keep the row open for a following column
                    if (page_q && !ref_pend_q) begin
                        state_q <= S_PRE;
                    end else begin
                        state_q <= S_RUP;
                    end
                end
                S_PRE: begin
                    // column precharge in page mode, then take a same-row column
                    if (cnt_q >= C_CP - 1) begin
                        if (page_hit) begin
                            op_q <= op_in;
                            col_q <= addr_in[7:0];
                            wdata_q <= wdata_in;
                            page_q <= page_in;
                            state_q <= S_RAS;
                            cnt_q <= {24'h0, C_RCD};
                        end else if (ref_pend_q || req_valid_in) begin
                            // refresh owed or another row wanted: close the page
                            state_q <= S_RUP;
                        end
                    end
                end
                S_RUP: begin
                    // hold row strobe low for its minimum width
                    if (ras_len_q >= C_RAS - 1) begin
                        // both strobes high ends the cycle
                        ras_n_out <= 1'b1;
                        cas_n_out <= 1'b1;
                        special_function_select_out <= 1'b0;
                        mask_write_enable_n_out <= 1'b1;
                        mask_or_data_pin_oe_out <= 1'b0;
                        cnt_q <= 32'h0;
                        state_q <= S_IDLE;
                        if (!init_done_out)
                            state_q <= S_CBR;
                    end
                end
                S_CBR: begin
                    // precharge met before any new row fall
                    if (ras_n_out && cas_n_out) begin
                        if (cnt_q >= C_RP - 1)
                            cas_n_out <= 1'b0;
                        cnt_q <= (cnt_q >= C_RP - 1) ? 32'h0 : cnt_q + 32'h1;
                    end else if (ras_n_out) begin
                        // every cycle refreshes a full row
                        if (cnt_q >= C_CSR - 1) begin
                            ras_n_out <= 1'b0;
                            ras_len_q <= 8'h0;
                            cnt_q <= 32'h0;
                        end
                    end else begin
                        if (cnt_q >= C_CHR - 1)
                            cas_n_out <= 1'b1;
                        if (ras_len_q >= C_RAS - 1) begin
                            ras_n_out <= 1'b1;
                            cas_n_out <= 1'b1;
                            ref_pend_q <= 1'b0;
                            cnt_q <= 32'h0;
                            if (!init_done_out) begin
                                // eight init cycles then normal use
                                init_cnt_q <= init_cnt_q + 4'h1;
                                if (init_cnt_q == `INIT_CYCLES - 1)
                                    init_done_out <= 1'b1;
                            end
                            // back to refresh until the last init cycle, then idle
                            if (init_done_out || init_cnt_q == `INIT_CYCLES - 1)
                                state_q <= S_IDLE;
                            else
                                state_q <= S_CBR;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule // vram_host
`default_nettype wire

//--- verilog/vram_host_defines.vh
`ifndef VRAM_HOST_DEFINES_VH
`define VRAM_HOST_DEFINES_VH

// address split
`define ROW_BITS 9
`define COL_BITS 8
`define ROWS 512
// block write keeps column bits 7..2
`define BLK_COL_LSB 2
// times in ns, rounded by the module
`define T_CLK_NS 20
`define T_RP_NS 60
`define T_RAS_NS 80
`define T_CAS_NS 20
`define T_RCD_NS 25
`define T_CP_NS 10
`define T_CSR_NS 10
`define T_CHR_NS 10
`define T_RWD_NS 105
`define T_CWD_NS 45
`define T_WCH_NS 15
`define T_CAC_NS 20
`define T_OEA_NS 20
// refresh period in us and power-up wait in us
`define T_REF_US 8000
`define T_PWRUP_US 200
`define INIT_CYCLES 8
// operation codes on op_in
`define OP_READ 3'h0
`define OP_WRITE 3'h1
`define OP_RMW 3'h2
`define OP_BLOCK 3'h3
`define OP_FLASH 3'h4

`endif
